//--- rtcc_regs.svh
// rtcc_regs.svh: register map, field positions, reset values and timing counts
// assumes: included by bare name into the clock core; definitions only
`ifndef RTCC_REGS_SVH
`define RTCC_REGS_SVH

// ************************************************************
// register byte addresses (full 32-bit wishbone address)
// ************************************************************
`define RTCC_CTRL_ADDR  32'h400e1460
`define RTCC_MODE_ADDR  32'h400e1464
`define RTCC_TIME_ADDR  32'h400e1468
`define RTCC_CAL_ADDR   32'h400e146c
`define RTCC_TALM_ADDR  32'h400e1470
`define RTCC_CALM_ADDR  32'h400e1474
`define RTCC_FLAG_ADDR  32'h400e1478
`define RTCC_FCLR_ADDR  32'h400e147c
`define RTCC_IEN_ADDR   32'h400e1480
`define RTCC_IDIS_ADDR  32'h400e1484
`define RTCC_IMSK_ADDR  32'h400e1488

// ************************************************************
// field positions
// ************************************************************
`define RTCC_CTRL_UPDT  0
`define RTCC_CTRL_UPDC  1
`define RTCC_CTRL_TEVL  8
`define RTCC_CTRL_CEVL  16
`define RTCC_MODE_H12   0
`define RTCC_MODE_PERL  28
`define RTCC_T_SEC      0
`define RTCC_T_MIN      8
`define RTCC_T_HOUR     16
`define RTCC_T_PM       22
`define RTCC_A_SEN      7
`define RTCC_A_MEN      15
`define RTCC_A_HEN      23
`define RTCC_C_HUNDREDS_OF_YEARS     0
`define RTCC_C_YEAR     8
`define RTCC_C_MON      16
`define RTCC_C_WDAY     21
`define RTCC_C_DATE     24
`define RTCC_CA_MEN     23
`define RTCC_CA_DEN     31
`define RTCC_FLAGS_W    5

// ************************************************************
// reset values
// ************************************************************
`define RTCC_CAL_RST    32'h01810720
`define RTCC_CALM_RST   32'h01010000

// ************************************************************
// timing: 125 ms base step at a 100 MHz clock
// ************************************************************
`define RTCC_CLK_MHZ    100
`define RTCC_STEP_MS    125
`define RTCC_STEP_CYC   (`RTCC_STEP_MS * 1000 * `RTCC_CLK_MHZ)

`endif

//--- rtcc_pkg.sv
// rtcc_pkg.sv: enumerations shared by the clock core and its bench
// assumes: field positions and addresses come from rtcc_regs.svh
package rtcc_pkg;

  // time event choice
  typedef enum logic [1:0] {
    RTCC_TEV_MIN  = 2'b00,
    RTCC_TEV_HOUR = 2'b01,
    RTCC_TEV_MIDN = 2'b10,
    RTCC_TEV_NOON = 2'b11
  } rtcc_tev_t;

  // calendar event choice
  typedef enum logic [1:0] {
    RTCC_CEV_WEEK = 2'b00,
    RTCC_CEV_MON  = 2'b01,
    RTCC_CEV_YEAR = 2'b10,
    RTCC_CEV_NONE = 2'b11
  } rtcc_cev_t;

  // output pulse period
  typedef enum logic [1:0] {
    RTCC_PER_1S   = 2'b00,
    RTCC_PER_500M = 2'b01,
    RTCC_PER_250M = 2'b10,
    RTCC_PER_125M = 2'b11
  } rtcc_per_t;

endpackage

//--- rtcc_core.sv
// rtcc_core.sv: bcd time and calendar counters, alarm, sticky flags
// assumes: classic wishbone master on clk_i, synchronous reset rst_i
`timescale 1ns/1ps
`include "rtcc_regs.svh"

module rtcc_core
  import rtcc_pkg::*;
#(
  parameter int STEP_CYC = `RTCC_STEP_CYC   // cycles per 125 ms step
)(
  input  wire logic        clk_i,           // system clock
  input  wire logic        rst_i,           // synchronous reset
  input  wire logic        cyc_i,           // wishbone cycle
  input  wire logic        stb_i,           // wishbone strobe
  input  wire logic        we_i,            // write enable
  input  wire logic [31:0] adr_i,           // byte address
  input  wire logic [3:0]  sel_i,           // byte lanes
  input  wire logic [31:0] dat_i,           // write data
  output logic      [31:0] dat_o,           // read data
  output logic             ack_o,           // answer
  output logic             irq_o,           // interrupt, level
  output logic             pulse_o,         // period pulse, one cycle
  output logic             sec_tick_o       // second tick, one cycle
);

  // ************************************************************
  // bus slave
  // ************************************************************
  logic        ack_q;        // registered answer
  logic [31:0] dat_q;        // registered read data
  logic [31:0] rdat;         // addressed register view
  logic [31:0] wmask;        // byte lanes expanded
  logic [31:0] wval;         // merged write value
  logic        req;          // request present
  logic        wr;           // write takes effect

  assign req   = cyc_i & stb_i;
  assign wr    = req & we_i & ack_q;
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}},
                  {8{sel_i[1]}}, {8{sel_i[0]}}};
  // untouched lanes keep the register's present value
  assign wval  = (rdat & ~wmask) | (dat_i & wmask);
  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // ack one cycle after the request, dropped the next
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q)
      begin
        dat_q <= rdat;       // unmapped reads give zero
      end
    end
  end

  // ************************************************************
  // state
  // ************************************************************
  logic       tupd_q;        // time update request
  logic       cupd_q;        // calendar update request
  rtcc_tev_t  tev_q;         // time event choice
  rtcc_cev_t  cev_q;         // calendar event choice
  logic       h12_q;         // twelve-hour select
  rtcc_per_t  per_q;         // pulse period select
  logic [6:0] sec_q;         // bcd seconds
  logic [6:0] min_q;         // bcd minutes
  logic [5:0] hour_q;        // bcd hours
  logic       pm_q;          // meridiem
  logic [6:0] hundreds_of_years_q;        // bcd century
  logic [7:0] year_q;        // bcd year
  logic [4:0] mon_q;         // bcd month
  logic [2:0] wday_q;        // weekday 1..7
  logic [5:0] date_q;        // bcd day of month
  logic [31:0] talm_q;       // time alarm image
  logic [31:0] calm_q;       // calendar alarm image
  logic [4:0] flag_q;        // sticky status flags
  logic [4:0] imsk_q;        // interrupt enables
  logic       irq_q;         // registered interrupt

  // write decode
  logic wr_ctrl, wr_mode, wr_time, wr_cal;
  logic wr_talm, wr_calm, wr_fclr, wr_ien, wr_idis;
  assign wr_ctrl = wr & (adr_i == `RTCC_CTRL_ADDR);
  assign wr_mode = wr & (adr_i == `RTCC_MODE_ADDR);
  // counters accept writes only while stopped for update
  assign wr_time = wr & (adr_i == `RTCC_TIME_ADDR) & tupd_q;
  assign wr_cal  = wr & (adr_i == `RTCC_CAL_ADDR) & cupd_q;
  assign wr_talm = wr & (adr_i == `RTCC_TALM_ADDR);
  assign wr_calm = wr & (adr_i == `RTCC_CALM_ADDR);
  assign wr_fclr = wr & (adr_i == `RTCC_FCLR_ADDR);
  assign wr_ien  = wr & (adr_i == `RTCC_IEN_ADDR);
  assign wr_idis = wr & (adr_i == `RTCC_IDIS_ADDR);

  // ************************************************************
  // read view
  // ************************************************************
  logic [31:0] time_v;       // time register view
  logic [31:0] cal_v;        // calendar register view
  assign time_v = {9'h000, pm_q, hour_q, 1'b0, min_q,
                   1'b0, sec_q};
  assign cal_v  = {2'b00, date_q, wday_q, mon_q, year_q,
                   1'b0, hundreds_of_years_q};

  // read mux; reserved bits and write-only registers give zero
  always_comb
  begin
    rdat = 32'h0000_0000;
    case (adr_i)
      `RTCC_CTRL_ADDR:
      begin
        rdat[`RTCC_CTRL_UPDT] = tupd_q;
        rdat[`RTCC_CTRL_UPDC] = cupd_q;
        rdat[`RTCC_CTRL_TEVL +: 2] = tev_q;
        rdat[`RTCC_CTRL_CEVL +: 2] = cev_q;
      end
      `RTCC_MODE_ADDR:
      begin
        rdat[`RTCC_MODE_H12] = h12_q;
        rdat[`RTCC_MODE_PERL +: 2] = per_q;
      end
      `RTCC_TIME_ADDR: rdat = time_v;
      `RTCC_CAL_ADDR:  rdat = cal_v;
      `RTCC_TALM_ADDR: rdat = talm_q;
      `RTCC_CALM_ADDR: rdat = calm_q;
      `RTCC_FLAG_ADDR: rdat = {27'h0, flag_q};
      `RTCC_IMSK_ADDR: rdat = {27'h0, imsk_q};
      default:         rdat = 32'h0000_0000;
    endcase
  end

  // ************************************************************
  // control and mode
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tupd_q <= 1'b0;
      cupd_q <= 1'b0;
      tev_q  <= RTCC_TEV_MIN;
      cev_q  <= RTCC_CEV_WEEK;
      h12_q  <= 1'b0;
      per_q  <= RTCC_PER_1S;
    end
    else
    begin
      if (wr_ctrl)
      begin
        tupd_q <= wval[`RTCC_CTRL_UPDT];
        cupd_q <= wval[`RTCC_CTRL_UPDC];
        tev_q  <= rtcc_tev_t'(wval[`RTCC_CTRL_TEVL +: 2]);
        cev_q  <= rtcc_cev_t'(wval[`RTCC_CTRL_CEVL +: 2]);
      end
      if (wr_mode)
      begin
        h12_q <= wval[`RTCC_MODE_H12];
        per_q <= rtcc_per_t'(wval[`RTCC_MODE_PERL +: 2]);
      end
    end
  end

  // ************************************************************
  // tick divider: 125 ms steps, eight make a second
  // ************************************************************
  logic [31:0] div_q;        // cycle count within a step
  logic [2:0]  step_q;       // step index within a second
  logic        step_en;      // one-cycle step enable
  logic        tick;         // one-second enable
  logic        tick_d_q;     // tick delayed for alarm compare
  logic        pulse_q;      // period pulse flop
  logic        per_hit;      // selected period boundary

  assign step_en = (div_q == 32'(STEP_CYC - 1));
  assign tick    = step_en & (step_q == 3'h7);

  // period boundary by step index
  always_comb
  begin
    case (per_q)
      RTCC_PER_1S:   per_hit = (step_q == 3'h7);
      RTCC_PER_500M: per_hit = (step_q[1:0] == 2'h3);
      RTCC_PER_250M: per_hit = step_q[0];
      RTCC_PER_125M: per_hit = 1'b1;
      default:       per_hit = 1'b0;
    endcase
  end

  // divider never stops, so stopped counting keeps phase
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_q    <= 32'h0;
      step_q   <= 3'h0;
      tick_d_q <= 1'b0;
      pulse_q  <= 1'b0;
    end
    else
    begin
      div_q    <= step_en ? 32'h0 : div_q + 32'h1;
      step_q   <= step_en ? step_q + 3'h1 : step_q;
      tick_d_q <= tick;
      pulse_q  <= step_en & per_hit;
    end
  end
  assign pulse_o    = pulse_q;
  assign sec_tick_o = tick_d_q;

  // ************************************************************
  // counter carries and next values
  // ************************************************************
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  logic       trun, crun;    // counting allowed
  logic       s_wrap, m_wrap, h_wrap;
  logic       c_min, c_hour, c_day, c_mon, c_year;
  logic       d_end, leap;
  logic [5:0] d_last;        // last bcd date of month
  logic [5:0] hour_n;        // next hour
  logic       pm_n;          // next meridiem
  logic [1:0] y_mod4;        // year modulo four

  assign trun   = tick & ~tupd_q;
  assign crun   = ~cupd_q;
  assign s_wrap = (sec_q == 7'h59);
  assign m_wrap = (min_q == 7'h59);
  // 24h rolls after 23, 12h after 11 pm
  assign h_wrap = h12_q ? (hour_q == 6'h11) & pm_q
                        : (hour_q == 6'h23);
  assign c_min  = trun & s_wrap;
  assign c_hour = c_min & m_wrap;
  assign c_day  = c_hour & h_wrap;
  assign y_mod4 = 2'({year_q[5:4], 1'b0} + {2'b00, year_q[1:0]});
  // 1900 is not a leap year, 2000 is
  assign leap   = (y_mod4 == 2'h0) &
                  ~((year_q == 8'h00) & (hundreds_of_years_q == 7'h19));
  assign d_end  = (date_q == d_last);
  assign c_mon  = c_day & crun & d_end;
  assign c_year = c_mon & (mon_q == 5'h12);

  // length of the current month in bcd
  always_comb
  begin
    case (mon_q)
      5'h02:   d_last = leap ? 6'h29 : 6'h28;
      5'h04,
      5'h06,
      5'h09,
      5'h11:   d_last = 6'h30;
      default: d_last = 6'h31;
    endcase
  end

  // hour sequence: 12h runs 12,1..11 and flips meridiem at 11
  always_comb
  begin
    pm_n   = pm_q;
    hour_n = 6'(bcd_inc({2'b00, hour_q}));
    if (h12_q)
    begin
      if (hour_q == 6'h12)
        hour_n = 6'h01;
      else if (hour_q == 6'h11)
        pm_n = ~pm_q;
    end
    else
    begin
      pm_n = 1'b0;
      if (h_wrap)
        hour_n = 6'h00;
    end
  end

  // ************************************************************
  // time counters
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sec_q  <= 7'h00;
      min_q  <= 7'h00;
      hour_q <= 6'h00;
      pm_q   <= 1'b0;
    end
    else if (wr_time)
    begin
      sec_q  <= wval[`RTCC_T_SEC +: 7];
      min_q  <= wval[`RTCC_T_MIN +: 7];
      hour_q <= wval[`RTCC_T_HOUR +: 6];
      pm_q   <= wval[`RTCC_T_PM];
    end
    else if (trun)
    begin
      sec_q <= s_wrap ? 7'h00 : 7'(bcd_inc({1'b0, sec_q}));
      if (c_min)
        min_q <= m_wrap ? 7'h00 : 7'(bcd_inc({1'b0, min_q}));
      if (c_hour)
      begin
        hour_q <= hour_n;
        pm_q   <= pm_n;
      end
    end
  end

  // ************************************************************
  // calendar counters
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hundreds_of_years_q <= 7'(`RTCC_CAL_RST >> `RTCC_C_HUNDREDS_OF_YEARS);
      year_q <= 8'(`RTCC_CAL_RST >> `RTCC_C_YEAR);
      mon_q  <= 5'(`RTCC_CAL_RST >> `RTCC_C_MON);
      wday_q <= 3'(`RTCC_CAL_RST >> `RTCC_C_WDAY);
      date_q <= 6'(`RTCC_CAL_RST >> `RTCC_C_DATE);
    end
    else if (wr_cal)
    begin
      hundreds_of_years_q <= wval[`RTCC_C_HUNDREDS_OF_YEARS +: 7];
      year_q <= wval[`RTCC_C_YEAR +: 8];
      mon_q  <= wval[`RTCC_C_MON +: 5];
      wday_q <= wval[`RTCC_C_WDAY +: 3];
      date_q <= wval[`RTCC_C_DATE +: 6];
    end
    else if (c_day & crun)
    begin
      // weekday cycles on its own; date ignores it
      wday_q <= (wday_q == 3'h7) ? 3'h1 : wday_q + 3'h1;
      date_q <= d_end ? 6'h01 : 6'(bcd_inc({2'b00, date_q}));
      if (c_mon)
        mon_q <= (mon_q == 5'h12) ? 5'h01
                 : 5'(bcd_inc({3'b000, mon_q}));
      if (c_year)
      begin
        year_q <= (year_q == 8'h99) ? 8'h00 : bcd_inc(year_q);
        if (year_q == 8'h99)
          hundreds_of_years_q <= 7'(bcd_inc({1'b0, hundreds_of_years_q}));
      end
    end
  end

  // ************************************************************
  // alarm images
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      talm_q <= 32'h0000_0000;
      calm_q <= `RTCC_CALM_RST;
    end
    else
    begin
      if (wr_talm)
        talm_q <= wval & 32'h00ff_ffff;
      if (wr_calm)
        calm_q <= wval & 32'hbf9f_0000;
    end
  end

  // ************************************************************
  // alarm compare, after the counters have advanced
  // ************************************************************
  logic a_sen, a_men, a_hen, a_moen, a_den, a_any, a_hit;
  assign a_sen  = talm_q[`RTCC_A_SEN];
  assign a_men  = talm_q[`RTCC_A_MEN];
  assign a_hen  = talm_q[`RTCC_A_HEN];
  assign a_moen = calm_q[`RTCC_CA_MEN];
  assign a_den  = calm_q[`RTCC_CA_DEN];
  assign a_any  = a_sen | a_men | a_hen | a_moen | a_den;
  // no enabled field means no alarm at all
  assign a_hit  = a_any
    & (~a_sen | (talm_q[`RTCC_T_SEC +: 7] == sec_q))
    & (~a_men | (talm_q[`RTCC_T_MIN +: 7] == min_q))
    & (~a_hen | (talm_q[`RTCC_T_HOUR +: 7] == {pm_q, hour_q}))
    & (~a_moen | (calm_q[`RTCC_C_MON +: 5] == mon_q))
    & (~a_den | (calm_q[`RTCC_C_DATE +: 6] == date_q));

  // ************************************************************
  // selected events
  // ************************************************************
  logic tev_hit, cev_hit, noon;
  // noon: hour goes 11 to 12 in the morning
  assign noon = c_hour & (hour_q == 6'h11) & (~h12_q | ~pm_q);

  always_comb
  begin
    case (tev_q)
      RTCC_TEV_MIN:  tev_hit = c_min;
      RTCC_TEV_HOUR: tev_hit = c_hour;
      RTCC_TEV_MIDN: tev_hit = c_day;
      RTCC_TEV_NOON: tev_hit = noon;
      default:       tev_hit = 1'b0;
    endcase
  end

  // week change is the roll from weekday 7 to weekday 1
  always_comb
  begin
    case (cev_q)
      RTCC_CEV_WEEK: cev_hit = c_day & crun & (wday_q == 3'h7);
      RTCC_CEV_MON:  cev_hit = c_mon;
      RTCC_CEV_YEAR: cev_hit = c_year;
      default:       cev_hit = 1'b0;
    endcase
  end

  // ************************************************************
  // sticky flags: set wins over a clear in the same cycle
  // ************************************************************
  logic [4:0] f_set;         // hardware set vector
  logic [4:0] f_clr;         // software clear vector
  assign f_set[0] = tick & (tupd_q | cupd_q);
  assign f_set[1] = tick_d_q & a_hit;
  assign f_set[2] = tick;
  assign f_set[3] = tev_hit;
  assign f_set[4] = cev_hit;
  assign f_clr    = wr_fclr ? dat_i[4:0] & {5{sel_i[0]}} : 5'h00;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flag_q <= 5'h00;
    else
      flag_q <= (flag_q & ~f_clr) | f_set;
  end

  // ************************************************************
  // interrupt enables and output
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      imsk_q <= 5'h00;
    else if (wr_ien)
      imsk_q <= imsk_q | (dat_i[4:0] & {5{sel_i[0]}});
    else if (wr_idis)
      imsk_q <= imsk_q & ~(dat_i[4:0] & {5{sel_i[0]}});
  end

  // registered so the pin never glitches
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_q <= 1'b0;
    else
      irq_q <= |(flag_q & imsk_q);
  end
  assign irq_o = irq_q;

endmodule

//--- rtcc_core_assertions.sv
// rtcc_core_assertions.sv: port checks for the clock core
// assumes: bound into rtcc_core, one clock, sync reset
`timescale 1ns/1ps
`include "rtcc_regs.svh"

module rtcc_chk #(
  parameter int STEP_CYC = 4
)(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [31:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        irq_o,
  input wire logic        pulse_o,
  input wire logic        sec_tick_o
);
  // ****
  // gap trackers
  // ****
  logic [1:0] per_q; // period seen on the bus
  int         pc_q;  // cycles since pulse
  int         sc_q;  // cycles since tick
  logic       pv_q;  // pulse gap valid
  logic       sv_q;  // tick gap valid
  logic       mw_q;  // mode write one edge ago
  wire        rd = ack_o && !we_i;
  wire        mw = ack_o && we_i && adr_i == `RTCC_MODE_ADDR;

  // a mode write restarts the gap, so a phase shift is not flagged;
  // the pulse launched at the write edge still follows the old period
  always_ff @(posedge clk_i)
  begin
    per_q <= rst_i ? 2'h0 : mw ? dat_i[`RTCC_MODE_PERL +: 2] : per_q;
    pc_q  <= pulse_o ? 0 : pc_q + 1;
    sc_q  <= sec_tick_o ? 0 : sc_q + 1;
    mw_q  <= mw;
    pv_q  <= !rst_i && !mw && !mw_q && (pulse_o || pv_q);
    sv_q  <= !rst_i && (sec_tick_o || sv_q);
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  ack_next_a:
    assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
  ack_pulse_a:
    assert property (ack_o |=> !ack_o) else $error("ack too long");
  reset_quiet_a:
    assert property ($fell(rst_i) |-> !ack_o && !irq_o && dat_o == 32'h0) else $error("reset dirty");
  wo_read_zero_a:
    assert property (rd && adr_i == `RTCC_IEN_ADDR |-> dat_o == 32'h0) else $error("enable read");
  time_spare_a:
    assert property (rd && adr_i == `RTCC_TIME_ADDR |-> dat_o[31:23] == 9'h0 && !dat_o[15] && !dat_o[7])
    else $error("spare bits set");
  sec_bcd_a:
    assert property (rd && adr_i == `RTCC_TIME_ADDR |-> dat_o[3:0] <= 4'h9 && dat_o[6:4] <= 3'h5)
    else $error("seconds not bcd");
  tick_gap_a:
    assert property (sec_tick_o && sv_q |-> sc_q == 8 * STEP_CYC - 1) else $error("tick gap");
  pulse_gap_a:
    assert property (pulse_o && pv_q |-> pc_q == (STEP_CYC << (3 - per_q)) - 1) else $error("pulse gap");
endmodule

bind rtcc_core rtcc_chk #(.STEP_CYC(STEP_CYC)) rtcc_chk_i (.clk_i, .rst_i, .cyc_i, .stb_i,
  .we_i, .adr_i, .dat_i, .dat_o, .ack_o, .irq_o, .pulse_o, .sec_tick_o);

//--- rtc_calendar_alarm_status_tb.sv
// rtc_calendar_alarm_status_tb.sv: self-checking bench for rtcc_core
// assumes: short step, wishbone driven from here, sel_i tied
`timescale 1ns/1ps
`include "rtcc_regs.svh"

module rtc_calendar_alarm_status_tb
  import rtcc_pkg::*;
;
  // ****
  // state
  // ****
  typedef struct packed {logic w; logic [31:0] a, d, e;} rtcc_row_t;
  logic        clk_i = 1'b0;
  logic        rst_i, cyc_i, stb_i, we_i, ack_o, irq_o, pulse_o, sec_tick_o;
  logic [31:0] adr_i, dat_i, dat_o, r;
  int          n_errors = 0;
  int          n_checks = 0;
  // reset values, masks, refused writes; all before the first tick
  rtcc_row_t   rows [8] = '{
    '{1'b0, `RTCC_CAL_ADDR, 32'h0, `RTCC_CAL_RST},
    '{1'b0, `RTCC_CALM_ADDR, 32'h0, `RTCC_CALM_RST},
    '{1'b0, `RTCC_FLAG_ADDR, 32'h0, 32'h0},
    '{1'b1, `RTCC_TIME_ADDR, 32'h00123456, 32'h0},
    '{1'b1, `RTCC_TALM_ADDR, 32'hffffffff, 32'h00ffffff},
    '{1'b1, `RTCC_CALM_ADDR, 32'hffffffff, 32'hbf9f0000},
    '{1'b1, `RTCC_IEN_ADDR, 32'h0, 32'h0},
    '{1'b1, 32'h400e1490, 32'h5a5a5a5a, 32'h0}};

  always #5 clk_i = ~clk_i;

  // one second is 64 cycles here
  rtcc_core #(.STEP_CYC(8)) rtcc_core_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i(4'hf), .dat_i, .dat_o, .ack_o, .irq_o, .pulse_o, .sec_tick_o);

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask

  // classic cycle; r takes data at the ack edge
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do
      @(posedge clk_i);
    while (ack_o !== 1'b1 && ++n < 20);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 20)
      n_errors++;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e, input string s);
    wb(1'b0, a, 32'h0);
    chk(s, e, r);
  endtask

  // bounded wait for the next second tick
  task automatic tick();
    int n = 0;
    do
      @(posedge clk_i);
    while (sec_tick_o !== 1'b1 && ++n < 200);
    if (n >= 200)
      n_errors++;
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // watchdog: the run needs about 1100 cycles
  initial
  begin
    #100000;
    n_errors++;
    conclude();
  end

  // main sequence
  initial
  begin
    rst_i <= 1'b1;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    adr_i <= 32'h0;
    dat_i <= 32'h0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (rows[i])
    begin
      if (rows[i].w)
        wb(1'b1, rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e, $sformatf("row %0d", i));
    end
    $display("table done");
    wb(1'b1, `RTCC_IEN_ADDR, 32'h1f);
    wb(1'b1, `RTCC_TALM_ADDR, 32'h80);
    wb(1'b1, `RTCC_CALM_ADDR, 32'h0);
    wb(1'b1, `RTCC_CTRL_ADDR, 32'h3);
    tick();
    rd(`RTCC_FLAG_ADDR, 32'h7, "grant");
    wb(1'b1, `RTCC_TIME_ADDR, 32'h00235958);
    wb(1'b1, `RTCC_CAL_ADDR, 32'h31f29919);
    tick();
    rd(`RTCC_TIME_ADDR, 32'h00235958, "held");
    wb(1'b1, `RTCC_FCLR_ADDR, 32'h1f);
    wb(1'b1, `RTCC_CTRL_ADDR, 32'h00020200);
    chk("irq off", 32'h0, {31'h0, irq_o});
    tick();
    tick();
    repeat (2) @(posedge clk_i);
    rd(`RTCC_TIME_ADDR, 32'h0, "midnight");
    rd(`RTCC_CAL_ADDR, 32'h01210020, "new year");
    rd(`RTCC_FLAG_ADDR, 32'h1e, "events");
    chk("irq on", 32'h1, {31'h0, irq_o});
    $display("rollover done");
    wb(1'b1, `RTCC_FCLR_ADDR, 32'h0);
    rd(`RTCC_FLAG_ADDR, 32'h1e, "no clear");
    wb(1'b1, `RTCC_FCLR_ADDR, 32'h1a);
    rd(`RTCC_FLAG_ADDR, 32'h04, "part clear");
    wb(1'b1, `RTCC_FCLR_ADDR, 32'h04);
    @(posedge clk_i);
    chk("irq low", 32'h0, {31'h0, irq_o});
    $display("flags done");
    // noon in 12-hour mode, hour alarm with meridiem; setup fits in one second
    tick();
    wb(1'b1, `RTCC_CTRL_ADDR, 32'h303);
    wb(1'b1, `RTCC_MODE_ADDR, 32'h1);
    wb(1'b1, `RTCC_TIME_ADDR, 32'h00115959);
    wb(1'b1, `RTCC_TALM_ADDR, 32'h00d20000);
    wb(1'b1, `RTCC_CTRL_ADDR, 32'h300);
    wb(1'b1, `RTCC_FCLR_ADDR, 32'h1f);
    tick();
    repeat (2) @(posedge clk_i);
    rd(`RTCC_TIME_ADDR, 32'h00520000, "noon");
    rd(`RTCC_FLAG_ADDR, 32'h0e, "noon flags");
    // 11:59:59 pm on weekday 7 rolls into a new week
    wb(1'b1, `RTCC_CTRL_ADDR, 32'h103);
    wb(1'b1, `RTCC_TIME_ADDR, 32'h00515959);
    wb(1'b1, `RTCC_CAL_ADDR, 32'h01e10020);
    wb(1'b1, `RTCC_CTRL_ADDR, 32'h100);
    wb(1'b1, `RTCC_FCLR_ADDR, 32'h1f);
    tick();
    repeat (2) @(posedge clk_i);
    rd(`RTCC_TIME_ADDR, 32'h00120000, "12 am");
    rd(`RTCC_CAL_ADDR, 32'h02210020, "next week");
    rd(`RTCC_FLAG_ADDR, 32'h1c, "week flags");
    $display("twelve hour done");
    for (int p = 0; p < 4; p++)
    begin
      wb(1'b1, `RTCC_MODE_ADDR, 32'(p) << 28);
      repeat (140) @(posedge clk_i);
    end
    $display("pulse done");
    // reset in mid-run brings every register back to its reset value
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("irq reset", 32'h0, {31'h0, irq_o});
    rd(`RTCC_CAL_ADDR, `RTCC_CAL_RST, "reset cal");
    rd(`RTCC_TIME_ADDR, 32'h0, "reset time");
    rd(`RTCC_MODE_ADDR, 32'h0, "reset mode");
    $display("reset done");
    conclude();
  end
endmodule
